// file: rtl/smt_defines.svh
// Register offsets, field positions, reset values and timing counts of the link initiator.
// What this block does
// - Read: lower select, then send 32-bit header with direction bit 0.
// - Header byte 0: direction bit 7, bank 6:3, size high 2:0; page, address.
// - Single-byte read carries a length field of zero.
// - Read of n bytes carries n-1; the target returns n sequential bytes.
// - After the header the initiator sends N zero flow-control bytes.
// - Read data is clocked in only after an idle answer, from byte 4+N.
// - Initiator sends 00h during read data and clocks exactly n bytes.
// - Write: send the 32-bit header with direction bit 1.
// - Single-byte write carries a length field of zero.
// - Write of n bytes carries n-1; target stores them sequentially.
// - During write flow control the initiator drives zeros and samples busy.
// - After idle, write data goes out from byte 4+N onward.
// - Every read, write or poll ends with select raised.
// - A busy poll is a one-byte read of bank 0, page 0, byte 0.
// - The poll header is all zero bits.
// - A poll sends 8N zero bits and reads the last flow byte.
// - Select falling starts and select rising stops a transaction.
// - Bytes go most significant bit first, eight bits a word.
// - A stop off a byte boundary or early aborts; partial bytes are dropped.
// - N is at least two; the target ignores the dummy bytes.
`ifndef SMT_DEFINES_SVH
`define SMT_DEFINES_SVH

`define SMT_REG_CTRL 4'h0
`define SMT_REG_HDR 4'h4
`define SMT_REG_STAT 4'h8
`define SMT_REG_DATA 4'hC

`define SMT_CTRL_START 0
`define SMT_CTRL_OP 2:1
`define SMT_CTRL_FLOW 7:4
`define SMT_CTRL_RST 32'h0000_0020
`define SMT_HDR_RST 32'h0000_0000

`define SMT_STAT_BUSY 0
`define SMT_STAT_DONE 1
`define SMT_STAT_ACK 2
`define SMT_STAT_NACK 3
`define SMT_STAT_PERR 4
`define SMT_STAT_RDV 5
`define SMT_STAT_WRF 6

`define SMT_FLOW_MIN 4'h2
`define SMT_HDR_BYTES 16'h0004
`define SMT_ACK_BYTE 8'h00
`define SMT_NACK_BYTE 8'hFF

`define SMT_CLK_NS 4
`define SMT_HALF_NS 32
`define SMT_HALF_CYC ((`SMT_HALF_NS + `SMT_CLK_NS - 1) / `SMT_CLK_NS)
`define SMT_GAP_NS 64
`define SMT_GAP_CYC ((`SMT_GAP_NS + `SMT_CLK_NS - 1) / `SMT_CLK_NS)

`endif

// file: rtl/smt_pkg.sv
// Types shared by the serial management link initiator.
`default_nettype none
package smt_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SEL  = 3'b001,
		ST_LOAD = 3'b010,
		ST_XFER = 3'b011,
		ST_STOP = 3'b100
	} smt_state_t;

	typedef enum logic [1:0] {
		OP_READ  = 2'b00,
		OP_WRITE = 2'b01,
		OP_TEST  = 2'b10
	} smt_op_t;

	typedef struct packed {
		logic        direction_bit;
		logic [3:0]  bank;
		logic [10:0] length_minus_one_field;
		logic [7:0]  page;
		logic [7:0]  addr;
	} smt_hdr_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} smt_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} smt_wb_rsp_t;
endpackage
`default_nettype wire

// file: rtl/smt_clk_gen.sv
// Serial clock divider with one-cycle edge enables.
`timescale 1ns/1ps
`default_nettype none
`include "smt_defines.svh"
module smt_clk_gen import smt_pkg::*; (
	input  wire logic core_clk, // core clock
	input  wire logic rst,      // synchronous reset
	input  wire logic run,      // clock runs while high
	output logic      sclk,     // serial clock, idles low
	output logic      rise_en,  // pulse at a rising serial edge
	output logic      fall_en   // pulse at a falling serial edge
);
	logic [7:0] cnt_q;
	logic       sclk_q;
	logic       tick;

	assign tick    = run && (cnt_q == 8'(`SMT_HALF_CYC - 1));
	assign rise_en = tick && !sclk_q;
	assign fall_en = tick && sclk_q;
	assign sclk    = sclk_q;

	always_ff @(posedge core_clk) begin
		if (rst || !run) begin
			cnt_q <= 8'h00;
		end else if (tick) begin
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst || !run) begin
			sclk_q <= 1'b0;
		end else if (tick) begin
			sclk_q <= !sclk_q;
		end
	end

	a_half_period: assert property (@(posedge core_clk) disable iff (rst)
		$rose(sclk_q) |-> sclk_q [*8] ##1 !sclk_q)
		else $error("serial clock high phase is not eight cycles");
endmodule
`default_nettype wire

// file: rtl/smt_initiator.sv
// Serial management link initiator with a Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "smt_defines.svh"
module smt_initiator import smt_pkg::*; (
	input  wire logic         core_clk,                     // core clock
	input  wire logic         rst,                          // synchronous reset
	input  wire smt_wb_req_t  wb_req,                       // Wishbone request
	output smt_wb_rsp_t       wb_rsp,                       // Wishbone answer
	output logic              select_low,                   // link select, low active
	output logic              link_clk,                     // link serial clock
	output logic              initiator_out_target_in_line, // serial data out
	input  wire logic         target_out_initiator_in_line  // serial data in
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [3:0] eff_flow(input logic [3:0] n);
		eff_flow = (n < `SMT_FLOW_MIN) ? `SMT_FLOW_MIN : n;
	endfunction

	function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] sel);
		lane_merge = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				lane_merge[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
	endfunction

	function automatic logic [7:0] hdr_byte(input smt_hdr_t h, input logic [1:0] idx);
		logic [31:0] w;
		w = h;
		hdr_byte = w[(3 - idx)*8 +: 8];
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	smt_state_t  state_q;
	smt_op_t     op_q;
	smt_op_t     t_op_q;
	smt_hdr_t    hdr_q;
	smt_hdr_t    t_hdr_q;
	logic [3:0]  flow_q;
	logic [3:0]  t_n_q;
	logic [15:0] pos_q;
	logic [3:0]  bit_q;
	logic [7:0]  tx_q;
	logic [7:0]  rx_q;
	logic [7:0]  tmr_q;
	logic        cs_n_q;
	logic        miso_s1_q;
	logic        miso_s2_q;
	logic        done_q;
	logic        ack_seen_q;
	logic        nack_q;
	logic        perr_q;
	logic [7:0]  rdata_q;
	logic        rd_valid_q;
	logic [7:0]  wdata_q;
	logic        wr_full_q;
	logic        ack_q;
	logic [31:0] rdat_q;
	logic [31:0] rdat_d;
	logic        hit;
	logic        wr_hit;
	logic        rd_hit;
	logic        start_go;
	logic        run;
	logic        rise_en;
	logic        fall_en;
	logic        xfer_done;
	logic        load_go;
	logic        can_load;
	logic        in_data;
	logic        at_last_flow;
	logic        end_now;
	logic [15:0] last_flow;
	logic [15:0] last_data;
	logic [7:0]  next_byte;

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	assign hit    = wb_req.cyc && wb_req.stb && !ack_q;
	// Writes commit at the edge where the master samples ack, not one edge early.
	assign wr_hit = wb_req.cyc && wb_req.stb && wb_req.we && ack_q;
	assign rd_hit = hit && !wb_req.we;
	assign start_go = wr_hit && (wb_req.adr == `SMT_REG_CTRL) && wb_req.sel[0]
		&& wb_req.dat[`SMT_CTRL_START] && (state_q == ST_IDLE)
		&& (wb_req.dat[`SMT_CTRL_OP] != 2'b11);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= hit;
		end
	end

	always_comb begin
		rdat_d = 32'h0000_0000;
		case (wb_req.adr)
			`SMT_REG_CTRL: begin
				rdat_d[`SMT_CTRL_START] = (state_q != ST_IDLE);
				rdat_d[`SMT_CTRL_OP]    = op_q;
				rdat_d[`SMT_CTRL_FLOW]  = flow_q;
			end
			`SMT_REG_HDR: begin
				rdat_d = hdr_q;
			end
			`SMT_REG_STAT: begin
				rdat_d[`SMT_STAT_BUSY] = (state_q != ST_IDLE);
				rdat_d[`SMT_STAT_DONE] = done_q;
				rdat_d[`SMT_STAT_ACK]  = ack_seen_q;
				rdat_d[`SMT_STAT_NACK] = nack_q;
				rdat_d[`SMT_STAT_PERR] = perr_q;
				rdat_d[`SMT_STAT_RDV]  = rd_valid_q;
				rdat_d[`SMT_STAT_WRF]  = wr_full_q;
			end
			`SMT_REG_DATA: begin
				rdat_d[7:0] = rdata_q;
			end
			default: begin
				rdat_d = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdat_q <= 32'h0000_0000;
		end else if (rd_hit) begin
			rdat_q <= rdat_d;
		end
	end

	assign wb_rsp.ack = ack_q;
	assign wb_rsp.dat = rdat_q;

	// Op and flow length only change while idle so a running frame stays coherent.
	always_ff @(posedge core_clk) begin
		logic [31:0] c;
		c = lane_merge({24'h000000, flow_q, 1'b0, op_q, 1'b0}, wb_req.dat, wb_req.sel);
		if (rst) begin
			op_q   <= smt_op_t'(`SMT_CTRL_RST >> 1);
			flow_q <= 4'(`SMT_CTRL_RST >> 4);
		end else if (wr_hit && (wb_req.adr == `SMT_REG_CTRL) && (state_q == ST_IDLE)) begin
			op_q   <= smt_op_t'(c[`SMT_CTRL_OP]);
			flow_q <= c[`SMT_CTRL_FLOW];
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			hdr_q <= `SMT_HDR_RST;
		end else if (wr_hit && (wb_req.adr == `SMT_REG_HDR)) begin
			hdr_q <= lane_merge(hdr_q, wb_req.dat, wb_req.sel);
		end
	end

	// ----------------------------------------------------------------
	// Transaction snapshot
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		smt_hdr_t h;
		h = lane_merge(hdr_q, wb_req.dat, 4'h0);
		if (rst) begin
			t_op_q  <= OP_READ;
			t_hdr_q <= `SMT_HDR_RST;
			t_n_q   <= `SMT_FLOW_MIN;
		end else if (start_go) begin
			t_op_q <= smt_op_t'(wb_req.dat[`SMT_CTRL_OP]);
			t_n_q  <= eff_flow(wb_req.dat[`SMT_CTRL_FLOW]);
			if (smt_op_t'(wb_req.dat[`SMT_CTRL_OP]) == OP_TEST) begin
				t_hdr_q <= '0;
			end else begin
				h.direction_bit = (wb_req.dat[`SMT_CTRL_OP] == OP_WRITE);
				t_hdr_q <= h;
			end
		end
	end

	// ----------------------------------------------------------------
	// Byte engine
	// ----------------------------------------------------------------
	assign last_flow    = `SMT_HDR_BYTES + {12'h000, t_n_q} - 16'h0001;
	assign last_data    = last_flow + {5'h00, t_hdr_q.length_minus_one_field} + 16'h0001;
	assign at_last_flow = (pos_q == last_flow);
	assign in_data      = (pos_q > last_flow);
	assign run          = (state_q == ST_XFER);
	assign xfer_done    = run && fall_en && (bit_q == 4'h8);
	assign can_load     = !in_data || ((t_op_q == OP_WRITE) ? wr_full_q : !rd_valid_q);
	assign load_go      = (state_q == ST_LOAD) && can_load;
	// A busy answer, a bad answer or the poll's answer ends the frame on the byte edge.
	assign end_now = (at_last_flow && ((t_op_q == OP_TEST) || (rx_q != `SMT_ACK_BYTE)))
		|| (in_data && (pos_q == last_data));

	always_comb begin
		if (pos_q < `SMT_HDR_BYTES) begin
			next_byte = hdr_byte(t_hdr_q, pos_q[1:0]);
		end else if (in_data && (t_op_q == OP_WRITE)) begin
			next_byte = wdata_q;
		end else begin
			next_byte = 8'h00;
		end
	end

	smt_clk_gen u_clk (
		.core_clk (core_clk),
		.rst      (rst),
		.run      (run),
		.sclk     (link_clk),
		.rise_en  (rise_en),
		.fall_en  (fall_en)
	);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			miso_s1_q <= 1'b0;
			miso_s2_q <= 1'b0;
		end else begin
			miso_s1_q <= target_out_initiator_in_line;
			miso_s2_q <= miso_s1_q;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start_go) begin
						state_q <= ST_SEL;
					end
				end
				ST_SEL: begin
					if (tmr_q == 8'h00) begin
						state_q <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					if (can_load) begin
						state_q <= ST_XFER;
					end
				end
				ST_XFER: begin
					if (xfer_done) begin
						state_q <= end_now ? ST_STOP : ST_LOAD;
					end
				end
				ST_STOP: begin
					if (tmr_q == 8'h00) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tmr_q <= 8'h00;
		end else if (start_go || (xfer_done && end_now)) begin
			tmr_q <= 8'(`SMT_GAP_CYC - 1);
		end else if (tmr_q != 8'h00) begin
			tmr_q <= tmr_q - 8'h01;
		end
	end

	// Select only rises on the same core edge as the last falling serial edge of a whole byte.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cs_n_q <= 1'b1;
		end else if (start_go) begin
			cs_n_q <= 1'b0;
		end else if (xfer_done && end_now) begin
			cs_n_q <= 1'b1;
		end
	end
	assign select_low = cs_n_q;

	always_ff @(posedge core_clk) begin
		if (rst || start_go) begin
			pos_q <= 16'h0000;
		end else if (xfer_done) begin
			pos_q <= pos_q + 16'h0001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			bit_q <= 4'h0;
		end else if (load_go) begin
			bit_q <= 4'h0;
		end else if (run && rise_en) begin
			bit_q <= bit_q + 4'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tx_q <= 8'h00;
		end else if (load_go) begin
			tx_q <= next_byte;
		end else if (run && fall_en) begin
			tx_q <= {tx_q[6:0], 1'b0};
		end
	end
	assign initiator_out_target_in_line = tx_q[7];

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rx_q <= 8'h00;
		end else if (run && rise_en) begin
			rx_q <= {rx_q[6:0], miso_s2_q};
		end
	end

	// ----------------------------------------------------------------
	// Status and data registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst || start_go) begin
			ack_seen_q <= 1'b0;
			nack_q     <= 1'b0;
			perr_q     <= 1'b0;
		end else if (xfer_done && at_last_flow) begin
			ack_seen_q <= (rx_q == `SMT_ACK_BYTE);
			nack_q     <= (rx_q == `SMT_NACK_BYTE);
			perr_q     <= (rx_q != `SMT_ACK_BYTE) && (rx_q != `SMT_NACK_BYTE);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			done_q <= 1'b0;
		end else if ((state_q == ST_STOP) && (tmr_q == 8'h00)) begin
			done_q <= 1'b1;
		end else if (wr_hit && (wb_req.adr == `SMT_REG_STAT) && wb_req.sel[0]
				&& wb_req.dat[`SMT_STAT_DONE]) begin
			done_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdata_q    <= 8'h00;
			rd_valid_q <= 1'b0;
		end else if (xfer_done && in_data && (t_op_q == OP_READ)) begin
			rdata_q    <= rx_q;
			rd_valid_q <= 1'b1;
		end else if (rd_hit && (wb_req.adr == `SMT_REG_DATA)) begin
			rd_valid_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wdata_q   <= 8'h00;
			wr_full_q <= 1'b0;
		end else if (wr_hit && (wb_req.adr == `SMT_REG_DATA) && wb_req.sel[0]) begin
			wdata_q   <= wb_req.dat[7:0];
			wr_full_q <= 1'b1;
		end else if (load_go && in_data && (t_op_q == OP_WRITE)) begin
			wr_full_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_flow_busy;
		xfer_done && at_last_flow && (rx_q == `SMT_NACK_BYTE);
	endsequence

	sequence s_last_data;
		xfer_done && in_data && (pos_q == last_data);
	endsequence

	a_dir_bit: assert property (
		(load_go && (pos_q == 16'h0000) && (t_op_q != OP_TEST))
		|=> tx_q[7] == (t_op_q == OP_WRITE))
		else $error("header direction bit does not match the operation");
	a_size_bits: assert property (
		(load_go && (pos_q == 16'h0000)) |=> tx_q[2:0] == t_hdr_q.length_minus_one_field[10:8])
		else $error("header byte 0 lacks the upper length bits");
	a_poll_zero: assert property (
		(load_go && (t_op_q == OP_TEST)) |=> tx_q == 8'h00)
		else $error("poll sent a nonzero byte");
	a_dummy_zero: assert property (
		(load_go && (pos_q >= `SMT_HDR_BYTES) && !(in_data && (t_op_q == OP_WRITE)))
		|=> tx_q == 8'h00)
		else $error("flow or read data byte is not zero");
	a_msb_first: assert property (
		(run && fall_en && (bit_q != 4'h8)) |=> initiator_out_target_in_line == $past(tx_q[6]))
		else $error("serial data is not shifted msb first");
	a_idle_high: assert property (
		(state_q == ST_IDLE) || (state_q == ST_XFER) |-> select_low == (state_q == ST_IDLE))
		else $error("select level does not frame the transfer");
	a_busy_stops: assert property (
		s_flow_busy |=> select_low && nack_q && (state_q == ST_STOP))
		else $error("busy answer did not end the frame");
	a_exact_count: assert property (
		s_last_data |=> select_low ##1 (state_q == ST_STOP))
		else $error("frame did not end after the announced byte count");
	a_data_after_ack: assert property (
		(load_go && in_data) |-> ack_seen_q)
		else $error("data moved without an idle answer");
	a_wb_single_ack: assert property (
		ack_q |=> !ack_q)
		else $error("bus answer lasted more than one cycle");
endmodule
`default_nettype wire

// file: dv/smt_target_model.sv
// Behavioural model of the managed target on the far side of the serial link.
`timescale 1ns/1ps
`default_nettype none
module smt_target_model import smt_pkg::*; (
	input  wire logic        core_clk,   // core clock, paces the released line
	input  wire logic        select_low, // link select, low active
	input  wire logic        link_clk,   // link serial clock
	input  wire logic        to_tgt,     // serial data from the initiator
	output logic             from_tgt,   // serial data to the initiator
	input  wire logic [3:0]  flow_n,     // flow byte count in use
	input  wire logic [7:0]  ans_byte,   // answer when not holding off
	output logic [31:0]      hdr_q,      // last header received
	output logic [15:0]      bytes_q,    // whole bytes of the last frame
	output logic             part_q,     // last frame stopped mid byte
	output logic [7:0]       viol_q      // dummy or ignored bytes that were not zero
);
	logic [7:0]  mem [0:255];
	logic [7:0]  sr;
	logic [7:0]  ans_v;
	logic [7:0]  rd;
	logic [15:0] cnt;
	logic        acked;
	logic        hold;
	logic        wrote;
	int          b;
	int          bi;

	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5C;
		{cnt, sr, acked, hold, wrote, from_tgt} = '0;
		{hdr_q, bytes_q, part_q, viol_q, ans_v} = '0;
	end

	// ----------------------------------------------------------------
	// Framing
	// ----------------------------------------------------------------
	always @(negedge select_low) begin
		cnt = '0;
		acked = 1'b0;
	end
	always @(posedge select_low) begin
		bytes_q = cnt >> 3;
		part_q = cnt[2:0] != 3'h0;
		hold = wrote && !part_q;
		wrote = 1'b0;
	end

	// ----------------------------------------------------------------
	// Receive on rising clock, answer on falling clock
	// ----------------------------------------------------------------
	always @(posedge link_clk) if (!select_low) begin
		sr = {sr[6:0], to_tgt};
		cnt = cnt + 16'h1;
		b = int'(cnt >> 3) - 1;
		if (cnt[2:0] == 3'h0) begin
			if (b < 4) hdr_q = {hdr_q[23:0], sr};
			if (b == 3) begin
				ans_v = hold ? 8'hFF : ans_byte;
				acked = ans_v == 8'h00;
			end
			if (b >= 4 && b < 4 + flow_n && sr != 8'h00) viol_q++;
			if (b >= 4 + flow_n && acked) begin
				if (hdr_q[31]) begin
					mem[hdr_q[7:0] + 8'(b - 4 - flow_n)] = sr;
					wrote = 1'b1;
				end else if (sr != 8'h00) viol_q++;
			end
		end
	end
	// Undefined bytes and a released line show a changing value, never the last bit.
	always @(negedge link_clk) if (!select_low) begin
		b = int'(cnt >> 3);
		bi = 7 - int'(cnt[2:0]);
		rd = mem[hdr_q[7:0] + 8'(b - 4 - flow_n)];
		if (b == 3 + flow_n) from_tgt = ans_v[bi];
		else if (b >= 4 + flow_n && acked && !hdr_q[31]) from_tgt = rd[bi];
		else from_tgt = ~from_tgt;
	end
	always @(posedge core_clk) if (select_low) from_tgt <= ~from_tgt;
endmodule
`default_nettype wire

// file: dv/smt_initiator_tb.sv
// Self-checking testbench of the link initiator against the target model.
`timescale 1ns/1ps
`default_nettype none
`include "smt_defines.svh"
module smt_initiator_tb import smt_pkg::*;;
	logic        core_clk;
	logic        rst;
	smt_wb_req_t wb_req;
	smt_wb_rsp_t wb_rsp;
	logic        select_low;
	logic        link_clk;
	logic        i_out;
	logic        t_out;
	logic [3:0]  flow_n;
	logic [7:0]  ans_byte;
	logic [31:0] hdr_seen;
	logic [15:0] bytes_seen;
	logic        part_seen;
	logic [7:0]  viol_seen;
	logic [7:0]  wdat [0:7];
	logic [7:0]  rexp [0:7];
	int          err_total;
	int          checked;

	smt_initiator smt_initiator_i (.core_clk(core_clk), .rst(rst), .wb_req(wb_req),
		.wb_rsp(wb_rsp), .select_low(select_low), .link_clk(link_clk),
		.initiator_out_target_in_line(i_out), .target_out_initiator_in_line(t_out));
	smt_target_model smt_target_model_i (.core_clk(core_clk), .select_low(select_low),
		.link_clk(link_clk), .to_tgt(i_out), .from_tgt(t_out), .flow_n(flow_n),
		.ans_byte(ans_byte), .hdr_q(hdr_seen), .bytes_q(bytes_seen), .part_q(part_seen),
		.viol_q(viol_seen));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask
	task automatic wb_cycle(input logic we, input logic [3:0] adr, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: d};
		@(posedge core_clk);
		while (wb_rsp.ack !== 1'b1 && n < 50) begin
			@(posedge core_clk);
			n++;
		end
		q = wb_rsp.dat;
		wb_req <= '0;
		@(posedge core_clk);
		if (n >= 50) begin
			err_total++;
			end_of_test();
		end
	endtask
	// One whole transaction; res is the status bit expected: 2 ack, 3 busy, 4 protocol error.
	task automatic xfer(input logic [1:0] op, input logic [3:0] bank, input logic [7:0] page,
		input logic [7:0] addr, input int n, input logic [3:0] nf, input int res);
		logic [31:0] s;
		logic [31:0] d;
		logic [31:0] hw;
		int          ri;
		int          wi;
		int          k;
		int          nt;
		ri = 0;
		wi = 0;
		k = 0;
		nt = (nf < 4'h2) ? 2 : int'(nf);
		flow_n <= 4'(nt);
		hw = {op == 2'd1, bank, 11'(n - 1), page, addr};
		wb_cycle(1'b1, `SMT_REG_STAT, 32'h2, s);
		wb_cycle(1'b1, `SMT_REG_HDR, hw, s);
		wb_cycle(1'b1, `SMT_REG_CTRL, {24'h0, nf, 1'b0, op, 1'b1}, s);
		do begin
			wb_cycle(1'b0, `SMT_REG_STAT, 32'h0, s);
			if (op == 2'd1 && s[6] === 1'b0 && wi < n) begin
				wb_cycle(1'b1, `SMT_REG_DATA, {24'h0, wdat[wi]}, d);
				wi++;
			end
			if (op == 2'd0 && s[5] === 1'b1) begin
				wb_cycle(1'b0, `SMT_REG_DATA, 32'h0, d);
				chk({24'h0, d[7:0]}, {24'h0, rexp[ri]});
				ri++;
			end
			k++;
		end while (s[1] !== 1'b1 && k < 3000);
		if (k >= 3000) begin
			err_total++;
			end_of_test();
		end
		chk({27'h0, s[4:0]}, 32'(1 << res) | 32'h2);
		chk(hdr_seen, (op == 2'd2) ? 32'h0 : hw);
		chk({16'h0, bytes_seen}, 4 + nt + ((res == 2 && op != 2'd2) ? n : 0));
		chk({31'h0, part_seen}, 32'h0);
		chk({24'h0, viol_seen}, 32'h0);
		chk(ri + wi, (res == 2 && op != 2'd2) ? n : 0);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		logic [31:0] q;
		wb_cycle(1'b0, `SMT_REG_CTRL, 32'h0, q);
		chk(q, `SMT_CTRL_RST);
		wb_cycle(1'b0, `SMT_REG_HDR, 32'h0, q);
		chk(q, `SMT_HDR_RST);
		wb_cycle(1'b0, `SMT_REG_STAT, 32'h0, q);
		chk(q, 32'h0);
		wb_cycle(1'b0, 4'h2, 32'h0, q);
		chk(q, 32'h0);
		chk({30'h0, select_low, link_clk}, 32'h2);
		$display("test reset done");
	endtask
	task automatic t_poll;
		xfer(2'd2, 4'h5, 8'h77, 8'h33, 4, 4'h1, 2);
		$display("test poll done");
	endtask
	task automatic t_read_one;
		rexp[0] = 8'h10 ^ 8'h5C;
		xfer(2'd0, 4'h3, 8'h05, 8'h10, 1, 4'h2, 2);
		$display("test read one done");
	endtask
	task automatic t_read_burst;
		for (int k = 0; k < 4; k++) rexp[k] = (8'hFE + 8'(k)) ^ 8'h5C;
		xfer(2'd0, 4'hF, 8'hFF, 8'hFE, 4, 4'h3, 2);
		$display("test read burst done");
	endtask
	task automatic t_bad_answer;
		ans_byte <= 8'h5A;
		xfer(2'd2, 4'h0, 8'h00, 8'h00, 1, 4'h2, 4);
		ans_byte <= 8'h00;
		$display("test bad answer done");
	endtask
	task automatic t_busy;
		ans_byte <= 8'hFF;
		xfer(2'd0, 4'h2, 8'h03, 8'h04, 2, 4'h2, 3);
		ans_byte <= 8'h00;
		$display("test busy done");
	endtask
	task automatic t_write_hold;
		wdat[0] = 8'h11;
		wdat[1] = 8'hA2;
		wdat[2] = 8'h3C;
		xfer(2'd1, 4'h1, 8'h02, 8'h40, 3, 4'h2, 2);
		xfer(2'd2, 4'h0, 8'h00, 8'h00, 1, 4'h2, 3);
		xfer(2'd2, 4'h0, 8'h00, 8'h00, 1, 4'h2, 2);
		for (int k = 0; k < 3; k++) rexp[k] = wdat[k];
		xfer(2'd0, 4'h1, 8'h02, 8'h40, 3, 4'h2, 2);
		wdat[0] = 8'h7E;
		xfer(2'd1, 4'h0, 8'h00, 8'hFF, 1, 4'h2, 2);
		$display("test write and hold-off done");
	endtask
	task automatic t_refuse;
		logic [31:0] q;
		int          k;
		k = 0;
		wb_cycle(1'b1, `SMT_REG_CTRL, 32'h0000_0037, q);
		wb_cycle(1'b0, `SMT_REG_STAT, 32'h0, q);
		chk({31'h0, q[0]}, 32'h0);
		wb_cycle(1'b0, `SMT_REG_CTRL, 32'h0, q);
		chk(q, 32'h0000_0036);
		wb_cycle(1'b1, `SMT_REG_CTRL, 32'h0000_0025, q);
		wb_cycle(1'b1, `SMT_REG_CTRL, 32'h0000_0013, q);
		wb_cycle(1'b0, `SMT_REG_CTRL, 32'h0, q);
		chk(q, 32'h0000_0025);
		do begin
			wb_cycle(1'b0, `SMT_REG_STAT, 32'h0, q);
			k++;
		end while (q[0] !== 1'b0 && k < 3000);
		if (k >= 3000) begin
			err_total++;
			end_of_test();
		end
		chk({16'h0, bytes_seen}, 32'h6);
		chk({31'h0, select_low}, 32'h1);
		$display("test refusal done");
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	initial begin
		rst = 1'b1;
		wb_req = '0;
		flow_n = 4'h2;
		ans_byte = 8'h00;
		err_total = 0;
		checked = 0;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		t_reset();
		t_poll();
		t_read_one();
		t_read_burst();
		t_bad_answer();
		t_busy();
		t_write_hold();
		t_refuse();
		end_of_test();
	end
endmodule
`default_nettype wire
